//--- design/rss_sequencer.sv
// Relay scan sequencer: scan steps, open actions, section setup and module names
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire rss_req_t reg_req,
    output logic [31:0] reg_rdata,
    input wire logic backplane_trigger_in,
    output logic backplane_trigger_out_n,
    output logic [NSECT-1:0] encode_n,
    output logic [NMOD-1:0][NCH-1:0] relay_state,
    output logic [NMOD-1:0][NSECT-1:0][1:0] sect_cfg,
    output logic busy
);
    typedef struct packed {
        rss_state_t state;
        logic [16:0] pre;
        logic [15:0] ms;
        logic [2:0] sub;
        logic [3:0] ptr;
        logic [15:0] passes;
        logic [15:0] count;
        logic [4:0] len;
        logic src_imm;
        logic tout_en;
        logic [15:0] tdly;
        logic [NMOD-1:0][15:0] odw;
        logic [NMOD-1:0][15:0] cdw;
        logic [31:0] arg;
        logic [31:0] name;
        logic [2:0] qres;
        logic [NMOD-1:0][31:0] names;
        logic [NMOD-1:0] nvalid;
        logic [NMOD-1:0] ncustom;
        logic [NMOD-1:0][NCH-1:0] relays;
        logic [NMOD-1:0][NSECT-1:0][1:0] cfg;
        logic [SCAN_DEPTH-1:0][9:0] scan;
        logic [2:0] esect;
        logic [31:0] rdata;
        logic [2:0] sync;
        logic trig_lvl;
        logic tout_n;
        logic [NSECT-1:0] enc_n;
    } rss_st_t;

    rss_st_t q, d;

    function automatic logic [31:0] to_upper(input logic [31:0] s);
        logic [31:0] r;
        r = s;
        for (int i = 0; i < 4; i++) begin
            if (s[i*8+:8] >= 8'h61 && s[i*8+:8] <= 8'h7A) begin
                r[i*8+:8] = s[i*8+:8] - 8'h20;
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] sect_of(input logic [7:0] ch);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 1; i < NSECT; i++) begin
            if (ch >= 8'(i * CH_SECT)) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    // Default catalog name is M plus slot digit
    function automatic logic [31:0] cat_name(input rss_st_t s, input int m);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (s.nvalid[m]) begin
            r = s.ncustom[m] ? s.names[m] : {8'h4D, 8'(8'h31 + m), 16'h0000};
        end
        return r;
    endfunction

    always_comb begin
        logic tfall, tdone, stepping;
        logic [3:0] nptr;
        logic [15:0] mx;
        logic [31:0] un;
        logic [7:0] lo, hi;
        rss_entry_t cur, nxt;
        d = q;
        tfall = 1'b0;
        tdone = 1'b0;
        stepping = 1'b0;
        nptr = 4'h0;
        mx = 16'h0000;
        un = to_upper(q.name);
        lo = q.arg[7:0];
        hi = q.arg[15:8];
        cur = q.scan[q.ptr];
        nxt = 10'h000;
        d.rdata = 32'h0000_0000;
        // Three-stage sync, level accepted when stages two and three agree
        d.sync = {q.sync[1:0], backplane_trigger_in};
        if (q.sync[1] == q.sync[2]) begin
            d.trig_lvl = q.sync[2];
            tfall = q.trig_lvl && !q.sync[2];
        end
        if (5'(q.ptr) + 5'h01 < q.len) begin
            nptr = q.ptr + 4'h1;
        end
        nxt = q.scan[nptr];
        // Millisecond timer; a zero load finishes at once
        tdone = (q.ms == 16'h0000);
        if (!tdone) begin
            if (q.pre == 17'(MS_CYCLES - 1)) begin
                d.pre = 17'h00000;
                d.ms = q.ms - 16'h0001;
            end else begin
                d.pre = q.pre + 17'h00001;
            end
        end
        case (q.state)
            RSS_IDLE: begin
            end
            RSS_ARMED: begin
                if (tfall) begin
                    d.state = RSS_TDLY;
                    d.ms = q.tdly;
                    d.pre = 17'h00000;
                end
            end
            RSS_TDLY: begin
                if (tdone) begin
                    d.relays[cur.mod][cur.ch] = 1'b0;
                    d.ms = q.odw[cur.mod];
                    d.pre = 17'h00000;
                    d.state = RSS_ODW;
                end
            end
            RSS_ODW: begin
                if (tdone) begin
                    d.relays[nxt.mod][nxt.ch] = 1'b1;
                    d.ms = q.cdw[nxt.mod];
                    d.pre = 17'h00000;
                    d.esect = sect_of(nxt.ch);
                    d.state = RSS_CDW;
                end
            end
            RSS_CDW: begin
                if (tdone) begin
                    d.sub = 3'h0;
                    d.ms = ENC_DELAY_MS;
                    d.pre = 17'h00000;
                    if (q.tout_en) begin
                        d.tout_n = 1'b0;
                        d.state = RSS_TOUT;
                    end else begin
                        d.state = RSS_EWAIT;
                    end
                end
            end
            RSS_TOUT: begin
                // 3 ns rounds up to one clock; encode delay starts after it
                d.ms = ENC_DELAY_MS;
                d.pre = 17'h00000;
                if (q.sub == 3'(TRIG_PULSE_CYC - 1)) begin
                    d.tout_n = 1'b1;
                    d.state = RSS_EWAIT;
                end else begin
                    d.sub = q.sub + 3'h1;
                end
            end
            RSS_EWAIT: begin
                if (tdone) begin
                    d.enc_n[q.esect] = 1'b0;
                    d.ms = ENC_WIDTH_MS;
                    d.pre = 17'h00000;
                    d.state = RSS_EPULSE;
                end
            end
            RSS_EPULSE: begin
                if (tdone) begin
                    d.enc_n = '1;
                    stepping = 1'b1;
                end
            end
            RSS_ACTDW: begin
                if (tdone) begin
                    d.state = RSS_IDLE;
                end
            end
            default: begin
                d.state = RSS_IDLE;
            end
        endcase
        // Step done: advance pointer and count finished passes
        if (stepping) begin
            d.ptr = nptr;
            d.state = q.src_imm ? RSS_TDLY : RSS_ARMED;
            d.ms = q.tdly;
            d.pre = 17'h00000;
            if (nptr == 4'h0) begin
                d.passes = q.passes + 16'h0001;
                if (q.count != 16'h0000 && q.passes + 16'h0001 == q.count) begin
                    d.state = RSS_IDLE;
                end
            end
        end
        if (reg_req.wr) begin
            case (reg_req.addr)
                A_CFG: begin
                    d.src_imm = reg_req.wdata[0];
                    d.tout_en = reg_req.wdata[1];
                end
                A_COUNT: d.count = reg_req.wdata[15:0];
                A_TDLY: d.tdly = reg_req.wdata[15:0];
                A_ARG: d.arg = reg_req.wdata;
                A_NAME: d.name = reg_req.wdata;
                A_LEN: d.len = reg_req.wdata[4:0];
                default: begin
                end
            endcase
            if (reg_req.addr[7:4] == A_ODW_HI) begin
                d.odw[reg_req.addr[3:2]] = reg_req.wdata[15:0];
            end
            if (reg_req.addr[7:4] == A_CDW_HI) begin
                d.cdw[reg_req.addr[3:2]] = reg_req.wdata[15:0];
            end
            if (reg_req.addr[7:6] == A_SCAN_HI) begin
                d.scan[reg_req.addr[5:2]] = {reg_req.wdata[1:0], reg_req.wdata[15:8]};
            end
        end
        // Actions other than abort are only taken while idle
        if (reg_req.wr && reg_req.addr == A_CMD) begin
            if (reg_req.wdata[3:0] == C_ABORT) begin
                d.state = RSS_IDLE;
                d.tout_n = 1'b1;
                d.enc_n = '1;
            end else if (q.state == RSS_IDLE) begin
                case (reg_req.wdata[3:0])
                    C_INIT: begin
                        if (q.len != 5'h00) begin
                            d.ptr = 4'h0;
                            d.passes = 16'h0000;
                            d.relays[q.scan[0][9:8]][q.scan[0][7:0]] = 1'b1;
                            d.state = q.src_imm ? RSS_TDLY : RSS_ARMED;
                            d.ms = q.tdly;
                            d.pre = 17'h00000;
                        end
                    end
                    C_OPEN_ALL: d.relays = '0;
                    C_OPEN_MOD: d.relays[q.arg[29:28]] = '0;
                    C_OPEN_LIST: begin
                        // One wait for the whole action, longest dwell wins
                        for (int m = 0; m < NMOD; m++) begin
                            if (q.arg[16+m]) begin
                                for (int c = 0; c < NCH; c++) begin
                                    if (8'(c) >= lo && 8'(c) <= hi) begin
                                        d.relays[m][c] = 1'b0;
                                    end
                                end
                                if (q.odw[m] > mx) begin
                                    mx = q.odw[m];
                                end
                            end
                        end
                        d.ms = mx;
                        d.pre = 17'h00000;
                        d.state = RSS_ACTDW;
                    end
                    C_CONFIG: begin
                        for (int s = 0; s < NSECT; s++) begin
                            if (q.arg[20+s]) begin
                                d.cfg[q.arg[29:28]][s] = q.arg[27:26];
                                for (int c = 0; c < CH_SECT; c++) begin
                                    d.relays[q.arg[29:28]][s*CH_SECT+c] = 1'b0;
                                end
                            end
                        end
                    end
                    C_DEFINE: begin
                        d.names[q.arg[29:28]] = un;
                        d.ncustom[q.arg[29:28]] = 1'b1;
                        d.nvalid[q.arg[29:28]] = 1'b1;
                    end
                    C_QUERY: begin
                        d.qres = 3'h0;
                        for (int m = 0; m < NMOD; m++) begin
                            if (q.nvalid[m] && cat_name(q, m) == un) begin
                                d.qres = 3'(m + 1);
                            end
                        end
                    end
                    C_DEL_NAME: begin
                        for (int m = 0; m < NMOD; m++) begin
                            if (q.nvalid[m] && cat_name(q, m) == un) begin
                                d.nvalid[m] = 1'b0;
                            end
                        end
                    end
                    C_DEL_ALL: d.nvalid = '0;
                    default: begin
                    end
                endcase
            end
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                A_CFG: d.rdata = {30'h0, q.tout_en, q.src_imm};
                A_STATUS: d.rdata = {q.passes, 4'h0, q.ptr, 3'h0, busy, q.state};
                A_COUNT: d.rdata = {16'h0000, q.count};
                A_TDLY: d.rdata = {16'h0000, q.tdly};
                A_ARG: d.rdata = q.arg;
                A_NAME: d.rdata = q.name;
                A_QRES: d.rdata = {29'h0, q.qres};
                A_LEN: d.rdata = {27'h0, q.len};
                default: begin
                end
            endcase
            if (reg_req.addr[7:4] == A_ODW_HI) begin
                d.rdata = {16'h0000, q.odw[reg_req.addr[3:2]]};
            end
            if (reg_req.addr[7:4] == A_CDW_HI) begin
                d.rdata = {16'h0000, q.cdw[reg_req.addr[3:2]]};
            end
            if (reg_req.addr[7:4] == A_CAT_HI) begin
                d.rdata = cat_name(q, int'(reg_req.addr[3:2]));
            end
            if (reg_req.addr[7:6] == A_SCAN_HI) begin
                d.rdata = {16'h0000, q.scan[reg_req.addr[5:2]][7:0], 6'h00,
                    q.scan[reg_req.addr[5:2]][9:8]};
            end
            for (int i = 0; i < SUPP_N; i++) begin
                if (reg_req.addr == A_SUPP + 8'(4 * i)) begin
                    d.rdata = {24'h000000, SUPP_CODE[i]};
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= RSS_IDLE;
            q.count <= COUNT_RST;
            q.tdly <= DWELL_RST;
            q.odw <= '0;
            q.cdw <= '0;
            q.nvalid <= '1;
            q.sync <= 3'h7;
            q.trig_lvl <= 1'b1;
            q.tout_n <= 1'b1;
            q.enc_n <= '1;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign backplane_trigger_out_n = q.tout_n;
    assign encode_n = q.enc_n;
    assign relay_state = q.relays;
    assign sect_cfg = q.cfg;
    assign busy = (q.state != RSS_IDLE);

    logic cmd_wr;
    assign cmd_wr = reg_req.wr && reg_req.addr == A_CMD;

    sequence s_tout_pulse;
        $fell(q.tout_n) ##1 q.tout_n;
    endsequence
    sequence s_enc_pulse;
        (q.state == RSS_EWAIT) ##1 !(&q.enc_n);
    endsequence

    chk_trig_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q.state == RSS_ARMED && q.sync[1] == q.sync[2] && q.trig_lvl && !q.sync[2]
        && !cmd_wr) |=> q.state == RSS_TDLY)
        else $error("trigger did not start a step");
    chk_delay_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q.state == RSS_TDLY && $past(q.state) == RSS_TDLY) |-> $stable(q.relays))
        else $error("relay changed during trigger delay");
    chk_open_cur: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q.state == RSS_ODW && $past(q.state) == RSS_TDLY)
        |-> !q.relays[q.scan[q.ptr][9:8]][q.scan[q.ptr][7:0]])
        else $error("current relay not opened");
    chk_close_nxt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q.state == RSS_CDW && $past(q.state) == RSS_ODW)
        |-> q.relays[q.scan[(5'(q.ptr) + 5'h01 < q.len) ? q.ptr + 4'h1 : 4'h0][9:8]]
        [q.scan[(5'(q.ptr) + 5'h01 < q.len) ? q.ptr + 4'h1 : 4'h0][7:0]])
        else $error("next relay not closed");
    chk_tout_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(q.tout_n) |-> s_tout_pulse and (q.state == RSS_TOUT && q.tout_en))
        else $error("trigger out pulse wrong");
    chk_enc_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(&q.enc_n) |-> $past(q.state) == RSS_EWAIT && q.state == RSS_EPULSE)
        else $error("encode pulse out of order");
    chk_enc_section: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_enc_pulse |-> $onehot(~q.enc_n) && !q.enc_n[q.esect])
        else $error("encode pulse on wrong section");
    chk_abort_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_wr && reg_req.wdata[3:0] == C_ABORT) |=> q.state == RSS_IDLE && q.tout_n)
        else $error("abort did not idle");
    chk_openall_cfg: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_wr && reg_req.wdata[3:0] == C_OPEN_ALL && q.state == RSS_IDLE)
        |=> q.relays == '0 && $stable(q.cfg))
        else $error("open-all wrong");
    chk_ignore_trig: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (q.state inside {RSS_ODW, RSS_CDW, RSS_EWAIT, RSS_EPULSE} && !cmd_wr)
        |=> q.state != RSS_TDLY || $past(q.state) == RSS_EPULSE)
        else $error("trigger restarted a running step");
endmodule

//--- design/rss_pkg.sv
// Shared constants, types and register map of the relay scan sequencer
package rss_pkg;
    localparam int NMOD = 4;
    localparam int NSECT = 6;
    localparam int CH_SECT = 40;
    localparam int NCH = NSECT * CH_SECT;
    localparam int SCAN_DEPTH = 16;
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_NS = 40;
    localparam int TRIG_PULSE_NS = 3;
    localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_CYC_DEF = CLK_HZ / 1000;
    localparam logic [15:0] ENC_DELAY_MS = 16'h0005;
    localparam logic [15:0] ENC_WIDTH_MS = 16'h0004;
    localparam logic [15:0] DWELL_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0001;
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_CFG = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_COUNT = 8'h0C;
    localparam logic [7:0] A_TDLY = 8'h10;
    localparam logic [7:0] A_ARG = 8'h14;
    localparam logic [7:0] A_NAME = 8'h18;
    localparam logic [7:0] A_QRES = 8'h1C;
    localparam logic [3:0] A_ODW_HI = 4'h2;
    localparam logic [3:0] A_CDW_HI = 4'h3;
    localparam logic [3:0] A_CAT_HI = 4'h4;
    localparam logic [7:0] A_LEN = 8'h60;
    localparam logic [1:0] A_SCAN_HI = 2'b10;
    localparam logic [7:0] A_SUPP = 8'hC0;
    localparam int SUPP_N = 5;
    // Arbitrary type codes for the supported module list
    localparam logic [SUPP_N-1:0][7:0] SUPP_CODE = {8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
    localparam logic [3:0] C_INIT = 4'h1;
    localparam logic [3:0] C_ABORT = 4'h2;
    localparam logic [3:0] C_OPEN_ALL = 4'h3;
    localparam logic [3:0] C_OPEN_MOD = 4'h4;
    localparam logic [3:0] C_OPEN_LIST = 4'h5;
    localparam logic [3:0] C_DEL_NAME = 4'h6;
    localparam logic [3:0] C_DEL_ALL = 4'h7;
    localparam logic [3:0] C_DEFINE = 4'h8;
    localparam logic [3:0] C_QUERY = 4'h9;
    localparam logic [3:0] C_CONFIG = 4'hA;
    typedef enum logic [1:0] {
        RSS_OWIRE = 2'b00, RSS_TWIRE = 2'b01, RSS_FWIRE = 2'b10
    } rss_wire_t;
    typedef enum logic [3:0] {
        RSS_IDLE = 4'b0000, RSS_ARMED = 4'b0001, RSS_TDLY = 4'b0010,
        RSS_ODW = 4'b0011, RSS_CDW = 4'b0100, RSS_TOUT = 4'b0101,
        RSS_EWAIT = 4'b0110, RSS_EPULSE = 4'b0111, RSS_ACTDW = 4'b1000
    } rss_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rss_req_t;
    typedef struct packed {
        logic [1:0] mod;
        logic [7:0] ch;
    } rss_entry_t;
endpackage

//--- tb/rss_trig_src.sv
// Backplane trigger source model driving the scan trigger pin
module rss_trig_src (
    input wire logic clk_sys,
    input wire logic fire,
    output logic backplane_trigger_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt = 0;
    // Pulled-up line: idle high between pulses
    initial backplane_trigger_in = 1'b1;
    always @(posedge clk_sys) begin
        if (fire) begin
            low_cnt <= 6; // Held long enough for the 3-flop filter
        end else if (low_cnt > 0) begin
            low_cnt <= low_cnt - 1;
        end
        backplane_trigger_in <= !(fire || low_cnt > 1);
    end
endmodule

//--- tb/rss_sequencer_test.sv
// Self-checking bench for the relay scan sequencer
module rss_sequencer_test
    import rss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic fire = 1'b0;
    rss_req_t reg_req = '0;
    logic [31:0] reg_rdata;
    logic trig_in, trig_out_n, busy, rd_d = 1'b0;
    logic [NSECT-1:0] encode_n;
    logic [NMOD-1:0][NCH-1:0] relay_state;
    logic [NMOD-1:0][NSECT-1:0][1:0] sect_cfg;
    logic [31:0] exp_q[$];
    logic [15:0] lf = 16'h0010;
    logic [31:0] nm;
    logic [31:0] up;
    int n_errors = 0;
    int n_tests = 0;
    int n_pulse = 0;
    int cyc = 0;
    int cnt;
    always #20 clk_sys = ~clk_sys;
    rss_sequencer #(.MS_CYCLES(MSC)) rss_sequencer_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .backplane_trigger_in(trig_in),
        .backplane_trigger_out_n(trig_out_n), .encode_n(encode_n),
        .relay_state(relay_state), .sect_cfg(sect_cfg), .busy(busy));
    rss_trig_src rss_trig_src_inst (.clk_sys(clk_sys), .fire(fire),
        .backplane_trigger_in(trig_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Busy is read one edge after the launching command
    task automatic wait_idle(input int lim);
        @(posedge clk_sys);
        cnt = 0;
        while (busy === 1'b1 && cnt < lim) begin
            @(posedge clk_sys);
            cnt++;
        end
    endtask
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask
    task automatic br(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_d) chk(reg_rdata, exp_q.pop_front());
        rd_d <= reg_req.rd;
        if (rst_n && trig_out_n === 1'b0) n_pulse++;
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        br(A_COUNT, 32'h1);
        br(8'hFC, 32'h0); // Unmapped place reads zero
        for (int m = 0; m < NMOD; m++) br(8'h40 + 8'(4 * m), 32'h4D310000 + (m << 16));
        for (int i = 0; i < SUPP_N; i++) br(A_SUPP + 8'(4 * i), 32'(SUPP_CODE[i]));
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            nm[8*i+:8] = 8'h61 + 8'(lf[3:0]); // Lower case in, upper case out
            up[8*i+:8] = 8'h41 + 8'(lf[3:0]);
        end
        bw(A_NAME, nm);
        bw(A_ARG, 32'h1000_0000);
        bw(A_CMD, 32'(C_DEFINE));
        br(8'h44, up);
        bw(A_CMD, 32'(C_QUERY));
        br(A_QRES, 32'h2);
        bw(A_CMD, 32'(C_DEL_NAME));
        br(8'h44, 32'h0);
        br(8'h48, 32'h4D330000);
        bw(A_CMD, 32'(C_DEL_ALL));
        for (int m = 0; m < NMOD; m++) br(8'h40 + 8'(4 * m), 32'h0);
        for (int w = 0; w < 3; w++) begin
            bw(A_ARG, 32'h03F1_0000 | (w << 26));
            bw(A_CMD, 32'(C_CONFIG));
            @(posedge clk_sys);
            chk(32'(sect_cfg[0]), 32'(w * 12'h555));
        end
        // Two-entry scan list, one triggered step: tdly 1 ms, open dwell 2 ms, close dwell 1 ms
        bw(A_TDLY, 32'h1);
        bw(8'h20, 32'h2);
        bw(8'h30, 32'h1);
        bw(A_COUNT, 32'h0);
        bw(A_CFG, 32'h2);
        bw(A_LEN, 32'h2);
        bw(8'h80, 32'h0);
        bw(8'h84, 32'h2D00);
        bw(A_CMD, 32'(C_INIT));
        repeat (2) @(posedge clk_sys);
        chk(32'(relay_state[0][0]), 32'h1);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (12) @(posedge clk_sys);
        fire <= 1'b1; // Late trigger inside the running step
        @(posedge clk_sys);
        fire <= 1'b0;
        cnt = 13;
        while (trig_out_n !== 1'b0 && cnt < 500) begin
            @(posedge clk_sys);
            cnt++;
        end
        chk(32'(cnt >= 4 * MSC && cnt < 500), 32'h1);
        chk(32'(relay_state[0][0]), 32'h0);
        chk(32'(relay_state[0][45]), 32'h1);
        cnt = 0;
        while (encode_n === 6'h3F && cnt < 500) begin
            @(posedge clk_sys);
            cnt++;
        end
        chk(32'(cnt >= 5 * MSC && cnt < 500), 32'h1);
        chk(32'(encode_n), 32'h3D);
        cnt = 0;
        while (encode_n !== 6'h3F && cnt < 500) begin
            @(posedge clk_sys);
            cnt++;
        end
        chk(32'(cnt >= 4 * MSC && cnt <= 4 * MSC + 1), 32'h1);
        repeat (60) @(posedge clk_sys);
        chk(n_pulse, 32'h1);
        bw(A_CMD, 32'(C_ABORT));
        @(posedge clk_sys);
        chk(32'(busy), 32'h0);
        bw(A_CMD, 32'(C_OPEN_ALL));
        repeat (2) @(posedge clk_sys);
        chk(32'(relay_state[0][45]), 32'h0);
        chk(32'(sect_cfg[0]), 32'hAAA);
        // Immediate source, two passes of the list, trigger out off
        bw(A_CFG, 32'h1);
        bw(A_COUNT, 32'h2);
        bw(A_CMD, 32'(C_INIT));
        wait_idle(1000);
        chk(32'(cnt >= 4 * 13 * MSC && cnt < 1000), 32'h1);
        br(A_STATUS, 32'h0002_0000);
        chk(n_pulse, 32'h1);
        chk(32'(relay_state[0][0]), 32'h1);
        chk(32'(relay_state[0][45]), 32'h0);
        // Section 0 to two-wire opens its closed relay
        bw(A_ARG, 32'h0410_0000);
        bw(A_CMD, 32'(C_CONFIG));
        @(posedge clk_sys);
        chk(32'(relay_state[0][0]), 32'h0);
        chk(32'(sect_cfg[0]), 32'hAA9);
        // Init then abort leaves entry 0 closed
        bw(A_CMD, 32'(C_INIT));
        bw(A_CMD, 32'(C_ABORT));
        bw(8'h24, 32'h3);
        bw(A_ARG, 32'h0003_0000);
        bw(A_CMD, 32'(C_OPEN_LIST));
        wait_idle(500);
        chk(32'(relay_state[0][0]), 32'h0);
        chk(32'(cnt >= 3 * MSC && cnt <= 3 * MSC + 1), 32'h1);
        bw(A_CMD, 32'(C_INIT));
        bw(A_CMD, 32'(C_ABORT));
        bw(A_ARG, 32'h1000_0000);
        bw(A_CMD, 32'(C_OPEN_MOD));
        @(posedge clk_sys);
        chk(32'(relay_state[0][0]), 32'h1);
        bw(A_ARG, 32'h0);
        bw(A_CMD, 32'(C_OPEN_MOD));
        @(posedge clk_sys);
        chk(32'(relay_state[0][0]), 32'h0);
        repeat (4) @(posedge clk_sys);
        finish_test();
    end
endmodule
